// ===== include/demag_limit_pkg.sv
/*
 * Constants shared by the half-bridge demagnetization and current-limit logic:
 * register offsets, field positions, reset values, pin codes, states and timing.
 * Assumes a 25 MHz device clock and an APB register bus with 8-bit addresses.
 */
package demag_limit_pkg;

    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [7:0]  ADDR_CONTROL       = 8'h00;
    localparam logic [7:0]  ADDR_STATUS        = 8'h04;

    localparam int          CTRL_SYNC_RECT     = 0;
    localparam int          CTRL_ASYNC_RECT    = 1;
    localparam int          CTRL_RECIRC_BRAKE  = 2;
    localparam int          CTRL_DUTY_40K      = 3;
    localparam int          CTRL_REG_CONFIG    = 4;
    localparam int          CTRL_WIDTH         = 5;
    localparam logic [4:0]  CTRL_RESET         = 5'h00;

    localparam int          STAT_LIMIT_HOLD    = 0;
    localparam int          STAT_DEMAG_ON      = 1;
    localparam int          STAT_OCP_24A       = 2;
    localparam int          STAT_GATE_HIGH     = 3;
    localparam int          STAT_GATE_LOW      = 6;
    localparam int          STAT_BLANKING      = 9;

    // ----------------------------------------
    // Four-level select pin, as digitised
    // ----------------------------------------
    localparam logic [1:0]  PIN_GROUND         = 2'h0;
    localparam logic [1:0]  PIN_GROUND_RES     = 2'h1;
    localparam logic [1:0]  PIN_OPEN           = 2'h2;
    localparam logic [1:0]  PIN_REGULATOR      = 2'h3;
    localparam int          PIN_BIT_24A        = 0;
    localparam int          PIN_BIT_RECT       = 1;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int          CLK_HZ             = 25_000_000;
    localparam int          FULL_DUTY_LOW_HZ   = 20_000;
    localparam int          FULL_DUTY_HIGH_HZ  = 40_000;
    localparam int          PERIOD_W           = 11;
    localparam logic [10:0] FULL_DUTY_LOW_CYC  = 11'(CLK_HZ / FULL_DUTY_LOW_HZ);
    localparam logic [10:0] FULL_DUTY_HIGH_CYC = 11'(CLK_HZ / FULL_DUTY_HIGH_HZ);
    localparam logic [3:0]  BLANK_CYCLES       = 4'h8;
    localparam logic [3:0]  MARGIN_CYCLES      = 4'h4;

    localparam int          PHASES             = 3;

    // ----------------------------------------
    // Per-phase commutation rectifier states
    // ----------------------------------------
    typedef enum logic [2:0] {
        COMM_IDLE      = 3'b000,
        COMM_WAIT_LOW  = 3'b001,
        COMM_WAIT_HIGH = 3'b010,
        COMM_RECT_LOW  = 3'b011,
        COMM_RECT_HIGH = 3'b100
    } comm_e;

endpackage

// ===== hdl/full_duty_clock.sv
/*
 * Internal PWM clock used to restart a PWM cycle when the input sits at 100% duty.
 * Assumes restart pulses on every rising edge of a high-side PWM input so the tick only fires when edges stop.
 */
`timescale 1ns/10ps
`default_nettype none

module full_duty_clock
    import demag_limit_pkg::*;
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic clk_en,
    // Control
    input  wire logic select_40k,
    input  wire logic restart,
    // Cycle start
    output var  logic tick
);

    typedef struct packed {
        logic [PERIOD_W-1:0] count;
        logic                tick;
    } fdc_s;

    fdc_s state;
    fdc_s next_state;
    logic [PERIOD_W-1:0] period;

    // ----------------------------------------
    // Counter
    // ----------------------------------------
    always_comb begin
        next_state = state;
        period = select_40k ? FULL_DUTY_HIGH_CYC : FULL_DUTY_LOW_CYC;
        next_state.tick = 1'b0;
        if (restart) begin
            next_state.count = '0;
        end else if (state.count >= period - 11'h001) begin
            next_state.count = '0;
            next_state.tick = 1'b1;
        end else begin
            next_state.count = state.count + 11'h001;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state <= '0;
        end else if (clk_en) begin
            state <= next_state;
        end
    end

    assign tick = state.tick;

endmodule

`default_nettype wire

// ===== hdl/half_bridge_demag_current_limit.sv
/*
 * Gate control for three half-bridges: active demagnetization (synchronous
 * rectification in commutation and PWM, asynchronous cut-off of negative
 * current) and cycle-by-cycle current limiting with blanking and recirculation.
 * Assumes comparators and the select pin arrive as clean digital levels,
 * synchronous to clk, and that an APB master reaches the registers.
 */
// Design decisions made here: the APB register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none

module half_bridge_demag_current_limit
    import demag_limit_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        clk_en,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    // PWM inputs from the controller
    input  wire logic [2:0]  pwm_high_in,
    input  wire logic [2:0]  pwm_low_in,
    // Comparators
    input  wire logic [2:0]  high_side_reverse_comparator,
    input  wire logic [2:0]  low_side_reverse_comparator,
    input  wire logic        limit_comparator,
    // Four-level select pin, digitised
    input  wire logic [1:0]  protection_rectify_select_pin,
    // Gate commands and status
    output var  logic [2:0]  gate_high,
    output var  logic [2:0]  gate_low,
    output var  logic        limit_active,
    output var  logic        overcurrent_24a
);

    typedef struct packed {
        logic [CTRL_WIDTH-1:0] ctrl;
        logic [2:0]            prev_high;
        logic [2:0]            prev_low;
        logic [2:0]            prev_lscmp;
        logic [2:0]            pwm_phase;
        logic [2:0]            aar_cut;
        comm_e [2:0]           mode;
        logic [2:0][3:0]       margin;
        logic [3:0]            blank;
        logic                  limit_hold;
        logic                  demag_on;
        logic                  ocp_24a;
        logic [2:0]            gate_high;
        logic [2:0]            gate_low;
        logic [31:0]           prdata;
        logic                  pready;
        logic                  pslverr;
    } top_s;

    top_s state;
    top_s next_state;

    logic tick;
    logic any_high_rise;

    // ----------------------------------------
    // Internal clock for 100% duty input
    // ----------------------------------------
    // The pin-configured variant has no rate choice and stays at the low rate.
    full_duty_clock u_full_duty_clock (
        .clk        (clk),
        .resetn     (resetn),
        .clk_en     (clk_en),
        .select_40k (state.ctrl[CTRL_REG_CONFIG] & state.ctrl[CTRL_DUTY_40K]),
        .restart    (any_high_rise),
        .tick       (tick)
    );

    assign any_high_rise = |(pwm_high_in & ~state.prev_high);

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        logic [2:0] rise_h;
        logic [2:0] fall_h;
        logic [2:0] rise_l;
        logic [2:0] fall_l;
        logic       cycle_start;
        logic       blanking;
        logic       hi_on;
        logic       lo_on;
        logic       asr_pwm;
        logic [31:0] status;

        next_state = state;
        rise_h = pwm_high_in & ~state.prev_high;
        fall_h = ~pwm_high_in & state.prev_high;
        rise_l = pwm_low_in & ~state.prev_low;
        fall_l = ~pwm_low_in & state.prev_low;
        blanking = (state.blank != 4'h0);
        cycle_start = any_high_rise | tick;
        hi_on = 1'b0;
        lo_on = 1'b0;
        asr_pwm = 1'b0;
        status = 32'h0000_0000;

        // ----------------------------------------
        // Edge history
        // ----------------------------------------
        next_state.prev_high = pwm_high_in;
        next_state.prev_low = pwm_low_in;
        next_state.prev_lscmp = low_side_reverse_comparator;

        // ----------------------------------------
        // Mode decode
        // ----------------------------------------
        // Select pin: bit 1 means rectify, bit 0 means the higher limit
        next_state.ocp_24a = protection_rectify_select_pin[PIN_BIT_24A];
        if (state.ctrl[CTRL_REG_CONFIG]) begin
            next_state.demag_on = state.ctrl[CTRL_SYNC_RECT] & state.ctrl[CTRL_ASYNC_RECT];
        end else begin
            next_state.demag_on = protection_rectify_select_pin[PIN_BIT_RECT];
        end

        // ----------------------------------------
        // Current limit
        // ----------------------------------------
        // Blanking restarts on every high-side PWM rising edge or internal tick
        if (cycle_start) begin
            next_state.blank = BLANK_CYCLES;
        end else if (blanking) begin
            next_state.blank = state.blank - 4'h1;
        end

        // Comparator is a digital level; reference range is kept by the system
        if (cycle_start) begin
            next_state.limit_hold = 1'b0;
        end else if (limit_comparator && !blanking) begin
            next_state.limit_hold = 1'b1;
        end

        // ----------------------------------------
        // Per-phase rectifiers and gates
        // ----------------------------------------
        for (int i = 0; i < PHASES; i++) begin
            // Commutation rectifier per phase
            case (state.mode[i])
                COMM_IDLE: begin
                    if (state.demag_on && fall_h[i] && |(rise_h & ~(3'b001 << i))) begin
                        next_state.mode[i] = COMM_WAIT_LOW;
                        next_state.margin[i] = MARGIN_CYCLES;
                    end else if (state.demag_on && fall_l[i] && |(rise_l & ~(3'b001 << i))) begin
                        next_state.mode[i] = COMM_WAIT_HIGH;
                        next_state.margin[i] = MARGIN_CYCLES;
                    end
                end
                COMM_WAIT_LOW: begin
                    if (pwm_high_in[i] || pwm_low_in[i] || !state.demag_on) begin
                        next_state.mode[i] = COMM_IDLE;
                    end else if (state.margin[i] == 4'h0) begin
                        next_state.mode[i] = COMM_RECT_LOW;
                    end else begin
                        next_state.margin[i] = state.margin[i] - 4'h1;
                    end
                end
                COMM_WAIT_HIGH: begin
                    if (pwm_high_in[i] || pwm_low_in[i] || !state.demag_on) begin
                        next_state.mode[i] = COMM_IDLE;
                    end else if (state.margin[i] == 4'h0) begin
                        next_state.mode[i] = COMM_RECT_HIGH;
                    end else begin
                        next_state.margin[i] = state.margin[i] - 4'h1;
                    end
                end
                COMM_RECT_LOW: begin
                    // Early stop once the diode current has died away
                    if (pwm_high_in[i] || pwm_low_in[i] || !state.demag_on ||
                        !low_side_reverse_comparator[i]) begin
                        next_state.mode[i] = COMM_IDLE;
                    end
                end
                COMM_RECT_HIGH: begin
                    if (pwm_high_in[i] || pwm_low_in[i] || !state.demag_on ||
                        !high_side_reverse_comparator[i]) begin
                        next_state.mode[i] = COMM_IDLE;
                    end
                end
                default: begin
                    next_state.mode[i] = COMM_IDLE;
                end
            endcase

            // A phase is PWM-driven on its high side only after a high edge
            if (next_state.mode[i] != COMM_IDLE || pwm_low_in[i]) begin
                next_state.pwm_phase[i] = 1'b0;
            end else if (rise_h[i]) begin
                next_state.pwm_phase[i] = 1'b1;
            end

            // Cut the low FET when its decaying current reaches zero
            if (!pwm_low_in[i]) begin
                next_state.aar_cut[i] = 1'b0;
            end else if (state.demag_on && state.prev_lscmp[i] && !low_side_reverse_comparator[i]) begin
                next_state.aar_cut[i] = 1'b1;
            end

            // Low-side diode conduction in the off-time of high-only PWM
            // A commutation that starts now must wait out its margin first
            asr_pwm = state.demag_on && state.pwm_phase[i] && !pwm_high_in[i] && !pwm_low_in[i] &&
                      low_side_reverse_comparator[i] && next_state.mode[i] == COMM_IDLE;

            // The limit hold also keeps rectification off the high side
            hi_on = (pwm_high_in[i] || state.mode[i] == COMM_RECT_HIGH) &&
                    !next_state.limit_hold;
            lo_on = (pwm_low_in[i] && !next_state.aar_cut[i]) || asr_pwm ||
                    state.mode[i] == COMM_RECT_LOW;
            if (next_state.limit_hold && state.ctrl[CTRL_RECIRC_BRAKE]) begin
                lo_on = 1'b1;
            end
            // Never both FETs of one leg together
            next_state.gate_high[i] = hi_on;
            next_state.gate_low[i] = lo_on && !hi_on;
        end

        // ----------------------------------------
        // Status word
        // ----------------------------------------
        status[STAT_LIMIT_HOLD] = state.limit_hold;
        status[STAT_DEMAG_ON] = state.demag_on;
        status[STAT_OCP_24A] = state.ocp_24a;
        status[STAT_GATE_HIGH +: 3] = state.gate_high;
        status[STAT_GATE_LOW +: 3] = state.gate_low;
        status[STAT_BLANKING] = blanking;

        // ----------------------------------------
        // APB: answer prepared in setup, so access needs no wait state
        // ----------------------------------------
        next_state.pready = 1'b0;
        next_state.pslverr = 1'b0;
        next_state.prdata = 32'h0000_0000;
        if (psel && !penable) begin
            next_state.pready = 1'b1;
            if (paddr == ADDR_CONTROL) begin
                next_state.prdata = {27'h0, state.ctrl};
            end else if (paddr == ADDR_STATUS) begin
                next_state.prdata = status;
            end else begin
                next_state.pslverr = 1'b1;
            end
        end
        if (psel && penable && state.pready && pwrite && paddr == ADDR_CONTROL) begin
            next_state.ctrl = pwdata[CTRL_WIDTH-1:0];
        end
        if (psel && penable && state.pready) begin
            next_state.prdata = 32'h0000_0000;
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (!resetn) begin
            state <= '0;
            state.ctrl <= CTRL_RESET;
        end else if (clk_en) begin
            state <= next_state;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign prdata = state.prdata;
    assign pready = state.pready;
    assign pslverr = state.pslverr;
    assign gate_high = state.gate_high;
    assign gate_low = state.gate_low;
    assign limit_active = state.limit_hold;
    assign overcurrent_24a = state.ocp_24a;

endmodule

`default_nettype wire

// ===== tb/pwm_ctrl_model.sv
/*
 * Behavioural controller on the PWM inputs: static levels per phase,
 * or a running PWM on one phase with an optional complementary low command.
 * Assumes the bench changes its commands just after a rising edge.
 */
`timescale 1ns/10ps
`default_nettype none

module pwm_ctrl_model (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       resetn,
    // Commands from the bench
    input  wire logic [2:0] static_high,
    input  wire logic [2:0] static_low,
    input  wire logic       run,
    input  wire logic       comp,
    input  wire logic [1:0] phase,
    input  wire logic [7:0] period,
    input  wire logic [7:0] duty,
    // PWM lines
    output var  logic [2:0] pwm_high,
    output var  logic [2:0] pwm_low
);
    logic [7:0] cnt;

    // Registered like a timer output, so edges sit just after the clock
    always @(posedge clk) begin
        cnt <= (!run || cnt + 8'h01 >= period) ? 8'h00 : cnt + 8'h01;
        pwm_high <= static_high;
        pwm_low <= static_low;
        if (!resetn) begin
            pwm_high <= 3'h0;
            pwm_low <= 3'h0;
        end else if (run) begin
            pwm_high[phase] <= cnt < duty;
            pwm_low[phase] <= comp && cnt >= duty;
        end
    end
endmodule

`default_nettype wire

// ===== tb/half_bridge_demag_current_limit_props.sv
/*
 * Port checker for the demag and current-limit block.
 * Assumes clk_en is held high and a single device clock.
 */
`timescale 1ns/10ps
`default_nettype none

module hb_props
    import demag_limit_pkg::*;
(
    // Clock, reset, bus
    input wire logic       clk,
    input wire logic       resetn,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pready,
    input wire logic       pslverr,
    // Inputs
    input wire logic [2:0] pwm_high_in,
    input wire logic       limit_comparator,
    input wire logic [1:0] protection_rectify_select_pin,
    // Outputs
    input wire logic [2:0] gate_high,
    input wire logic [2:0] gate_low,
    input wire logic       limit_active,
    input wire logic       overcurrent_24a
);
    logic [2:0]  prev_high;
    logic [11:0] held;
    wire         rise = |(pwm_high_in & ~prev_high);
    wire         pin_24a = protection_rectify_select_pin[0];

    // Length of one hold; no wrap before the bound is hit
    always_ff @(posedge clk) begin
        prev_high <= pwm_high_in;
        if (!resetn || rise || !limit_active) begin
            held <= 12'h000;
        end else begin
            held <= held + 12'h001;
        end
    end

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    AST_APB_PULSE:
        assert property (psel && !penable |=> pready ##1 !pready)
        else $error("pready not one cycle");
    AST_ERR_WITH_READY:
        assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    AST_OCP_LEVEL:
        assert property ($past(resetn) |-> overcurrent_24a == $past(pin_24a))
        else $error("limit level off pin");
    AST_TRIP_CAUSE:
        assert property ($rose(limit_active) |-> $past(limit_comparator))
        else $error("hold without trip");
    AST_BLANKING:
        assert property (rise |=> !limit_active [*8])
        else $error("trip in blanking");
    AST_HOLD_GATE:
        assert property (limit_active && $past(limit_active) |-> gate_high == 3'h0)
        else $error("high side on in hold");
    AST_NO_SHOOT:
        assert property ((gate_high & gate_low) == 3'h0)
        else $error("both FETs of a phase on");
    AST_FULL_DUTY:
        assert property (limit_active |-> held <= 12'h4E4)
        else $error("hold outlived internal period");

    COVER_TRIP: cover property ($rose(limit_active));
    COVER_BRAKE: cover property (limit_active && gate_low == 3'h7);
    COVER_TICK: cover property ($fell(limit_active) && !$past(rise));
endmodule

bind half_bridge_demag_current_limit hb_props hb_props_i (
    .clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .pwm_high_in(pwm_high_in),
    .limit_comparator(limit_comparator),
    .protection_rectify_select_pin(protection_rectify_select_pin),
    .gate_high(gate_high), .gate_low(gate_low),
    .limit_active(limit_active), .overcurrent_24a(overcurrent_24a)
);

`default_nettype wire

// ===== tb/tb.sv
/*
 * Self-checking bench for the demag and current-limit block.
 * Assumes the PWM controller model and APB tasks below; clk_en held high.
 */
`timescale 1ns/10ps
`default_nettype none

module tb
    import demag_limit_pkg::*;
;
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic        pready, pslverr, limit_active, overcurrent_24a;
    logic [2:0]  sh = 3'h0, sl = 3'h0, hs_cmp = 3'h0, ls_cmp = 3'h0;
    logic [2:0]  pwm_high, pwm_low, gate_high, gate_low;
    logic        lim = 1'b0, run = 1'b0;
    logic [1:0]  pin = 2'h0;
    int          mismatches = 0, n_tests = 0, cycles = 0, n;

    always #20 clk = ~clk;

    half_bridge_demag_current_limit half_bridge_demag_current_limit_i (
        .clk(clk), .resetn(resetn), .clk_en(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pwm_high_in(pwm_high), .pwm_low_in(pwm_low),
        .high_side_reverse_comparator(hs_cmp), .low_side_reverse_comparator(ls_cmp),
        .limit_comparator(lim), .protection_rectify_select_pin(pin),
        .gate_high(gate_high), .gate_low(gate_low),
        .limit_active(limit_active), .overcurrent_24a(overcurrent_24a)
    );

    pwm_ctrl_model pwm_ctrl_model_i (
        .clk(clk), .resetn(resetn), .static_high(sh), .static_low(sl),
        .run(run), .comp(1'b0), .phase(2'h0), .period(8'h28), .duty(8'h14),
        .pwm_high(pwm_high), .pwm_low(pwm_low)
    );

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic err);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        chk({30'h0, pslverr, pready}, {30'h0, err, 1'b1});
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wait_rise();
        n = 0;
        while (pwm_high[0] !== 1'b0 && n < 100) begin
            @(posedge clk);
            n++;
        end
        while (pwm_high[0] !== 1'b1 && n < 100) begin
            @(posedge clk);
            n++;
        end
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic s_regs();
        apb(1'b0, ADDR_CONTROL, 32'h0, 1'b0);
        chk(rd, 32'(CTRL_RESET));
        apb(1'b1, ADDR_CONTROL, 32'h1F, 1'b0);
        apb(1'b1, ADDR_STATUS, 32'h3FF, 1'b0);
        apb(1'b0, ADDR_CONTROL, 32'h0, 1'b0);
        chk(rd, 32'h1F);
        apb(1'b1, 8'h08, 32'h1, 1'b1);
        apb(1'b0, 8'h08, 32'h0, 1'b1);
        chk(rd, 32'h0);
        apb(1'b1, ADDR_CONTROL, 32'h0, 1'b0);
    endtask

    task automatic s_mode();
        for (int k = 0; k < 4; k++) begin
            pin <= 2'(k);
            repeat (3) @(posedge clk);
            apb(1'b0, ADDR_STATUS, 32'h0, 1'b0);
            chk(32'(rd[2:1]), 32'({pin[0], pin[1]}));
            chk(32'(overcurrent_24a), 32'(pin[0]));
            apb(1'b1, ADDR_CONTROL, 32'h10 | 32'(k), 1'b0);
            apb(1'b0, ADDR_STATUS, 32'h0, 1'b0);
            chk(32'(rd[1]), 32'(k == 3));
            apb(1'b1, ADDR_CONTROL, 32'h0, 1'b0);
        end
    endtask

    task automatic s_comm(input logic hs);
        sh <= hs ? 3'h0 : 3'h1;
        sl <= hs ? 3'h1 : 3'h0;
        repeat (12) @(posedge clk);
        sh <= hs ? 3'h0 : 3'h4;
        sl <= hs ? 3'h4 : 3'h0;
        @(posedge clk);
        hs_cmp <= {2'h0, hs};
        ls_cmp <= {2'h0, !hs};
        n = 0;
        while ((hs ? gate_high[0] : gate_low[0]) !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        chk(32'(n >= int'(MARGIN_CYCLES) && n < 20), 32'h1);
        hs_cmp <= 3'h0;
        ls_cmp <= 3'h0;
        repeat (4) @(posedge clk);
        chk(32'(hs ? gate_high[0] : gate_low[0]), 32'h0);
        sh <= 3'h0;
        sl <= 3'h0;
        repeat (4) @(posedge clk);
    endtask

    task automatic s_asr(input logic [1:0] p);
        pin <= p;
        sh <= 3'h2;
        repeat (4) @(posedge clk);
        sh <= 3'h0;
        repeat (2) @(posedge clk);
        ls_cmp <= 3'h2;
        repeat (3) @(posedge clk);
        chk(32'(gate_low), 32'({p[1], 1'b0}));
        ls_cmp <= 3'h0;
        repeat (3) @(posedge clk);
        chk(32'(gate_low), 32'h0);
    endtask

    task automatic s_aar(input logic [1:0] p);
        pin <= p;
        ls_cmp <= 3'h2;
        sl <= 3'h2;
        repeat (4) @(posedge clk);
        chk(32'(gate_low), 32'h2);
        ls_cmp <= 3'h0;
        repeat (3) @(posedge clk);
        chk(32'(gate_low), p[1] ? 32'h0 : 32'h2);
        sl <= 3'h0;
        repeat (3) @(posedge clk);
    endtask

    task automatic s_limit(input logic brake);
        apb(1'b1, ADDR_CONTROL, brake ? 32'h14 : 32'h10, 1'b0);
        run <= 1'b1;
        wait_rise();
        lim <= 1'b1;
        repeat (3) @(posedge clk);
        lim <= 1'b0;
        repeat (3) @(posedge clk);
        chk(32'(limit_active), 32'h0);
        wait_rise();
        repeat (12) @(posedge clk);
        lim <= 1'b1;
        @(posedge clk);
        lim <= 1'b0;
        repeat (2) @(posedge clk);
        chk(32'({limit_active, gate_high}), 32'h8);
        chk(32'(gate_low), brake ? 32'h7 : 32'h0);
        repeat (3) @(posedge clk);
        chk(32'(limit_active), 32'h1);
        wait_rise();
        repeat (2) @(posedge clk);
        chk(32'({limit_active, gate_high}), 32'h1);
        run <= 1'b0;
        repeat (4) @(posedge clk);
    endtask

    task automatic s_full(input logic fast);
        int cyc;
        cyc = fast ? int'(FULL_DUTY_HIGH_CYC) : int'(FULL_DUTY_LOW_CYC);
        apb(1'b1, ADDR_CONTROL, fast ? 32'h18 : 32'h10, 1'b0);
        sh <= 3'h1;
        @(posedge clk);
        repeat (12) @(posedge clk);
        lim <= 1'b1;
        @(posedge clk);
        lim <= 1'b0;
        repeat (3) @(posedge clk);
        chk(32'(limit_active), 32'h1);
        n = 17;
        while (limit_active !== 1'b0 && n < 3000) begin
            @(posedge clk);
            n++;
        end
        chk(32'(n >= cyc && n <= cyc + 4), 32'h1);
        sh <= 3'h0;
        repeat (4) @(posedge clk);
    endtask

    task automatic final_report();
        $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // Ceiling well above the roughly 2300 cycles the scenarios need
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            final_report();
        end
    end

    initial begin
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        s_regs();
        s_mode();
        s_comm(1'b0);
        s_comm(1'b1);
        s_asr(2'h1);
        s_asr(2'h3);
        s_aar(2'h1);
        s_aar(2'h3);
        s_limit(1'b1);
        s_limit(1'b0);
        s_full(1'b0);
        s_full(1'b1);
        final_report();
    end
endmodule

`default_nettype wire
